// ### pkg/mcc_map.svh
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH
// register indices, byte address is four times the index
`define MCC_IDX_PLL_GRID    14'h2868
`define MCC_IDX_ANALOG      14'h286B
`define MCC_IDX_CHAN_EN     14'h2878
`define MCC_IDX_GAIN        14'h2879
`define MCC_IDX_FILTER_GAIN 14'h287A
`define MCC_IDX_IRQ_STATUS  14'h2880
`define MCC_IDX_IRQ_MASK    14'h2881
// reset values
`define MCC_RST_PLL_GRID    8'h00
`define MCC_RST_CHAN_EN     8'h00
`define MCC_RST_GAIN        8'h00
`define MCC_RST_FILTER_GAIN 8'h00
`define MCC_RST_IRQ         2'h0
// pll_grid_control fields
`define MCC_GRID_SEL_BIT    5
// analog_state fields
`define MCC_XTAL_FAIL_BIT   7
`define MCC_COMP_BIT        5
`define MCC_ANA_FIXED       3'h5
// channel_enable_control fields
`define MCC_PHC_EN_BIT      6
`define MCC_SWAP_BIT        5
`define MCC_AUX_PROC_BIT    4
`define MCC_AUX_IN_BIT      3
`define MCC_I2_IN_BIT       2
`define MCC_I1_IN_BIT       1
`define MCC_V_IN_BIT        0
// digital_gain_control fields
`define MCC_I1_SIGN_BIT     7
`define MCC_I1_EXP_HI       6
`define MCC_I1_EXP_LO       4
`define MCC_V_SIGN_BIT      3
`define MCC_V_EXP_HI        2
`define MCC_V_EXP_LO        0
// filter_gain_control fields
`define MCC_V_QUARTER_BIT   5
// gain limits
`define MCC_EXP_MAX         3'h5
`define MCC_QUARTER_SHIFT   2
// interrupt status bits
`define MCC_IRQ_XTAL_BIT    0
`define MCC_IRQ_COMP_BIT    1
`endif

// ### pkg/mcc_pkg.sv
package mcc_pkg;
   typedef logic signed [23:0] mcc_smp_t;
   typedef logic signed [29:0] mcc_out_t;
   // raw samples from the modulators
   typedef struct packed {
      mcc_smp_t v;
      mcc_smp_t ia;
      mcc_smp_t ib;
      mcc_smp_t aux;
   } mcc_smp_s;
   // gated, routed and scaled samples
   typedef struct packed {
      mcc_out_t v;
      mcc_out_t i1;
      mcc_out_t i2;
      mcc_out_t aux;
   } mcc_path_s;
endpackage

// ### core/mcc_regs.sv
// Notes on behaviour
// - grid select: clear 50Hz, set 60Hz
// - crystal fail reads one, RC takes over
// - comparator bit follows positive over negative
// - analog fixed field reads five
// - every reset source restores defaults
// - phase compensation per current when enabled
// - swap exchanges current A and B routing
// - aux processing enable turns aux calculations
// - aux input disabled feeds zeros
// - second current disabled feeds zeros
// - first current disabled feeds zeros
// - voltage disabled feeds zeros
// - first current sign negates gain
// - first current gain two to exponent
// - voltage sign negates gain
// - voltage gain two to exponent
// - quarter bit divides voltage gain four
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mcc_map.svh"
module mcc_regs (
   // clock and reset (all reset sources merged upstream)
   input  wire logic               core_clk_i,
   input  wire logic               rst_b_i,
   // apb slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [15:0]        paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   // analog status pins
   input  wire logic               crystal_fail_i,
   input  wire logic               comp_out_i,
   // sample stream
   input  wire logic               smp_valid_i,
   input  wire mcc_pkg::mcc_smp_s  smp_i,
   output mcc_pkg::mcc_path_s      path_o,
   output logic                    path_valid_o,
   // controls to the datapath and clocking
   output logic                    grid_freq_select_o,
   output logic                    clk_src_rc_o,
   output logic                    phase_comp_enable_o,
   output logic                    aux_processing_enable_o,
   // interrupt
   output logic                    irq_o
);

   // register state
   logic [7:0]  pll_grid_ff,    nxt_pll_grid;
   logic [7:0]  chan_en_ff,     nxt_chan_en;
   logic [7:0]  gain_ff,        nxt_gain;
   logic [7:0]  filt_gain_ff,   nxt_filt_gain;
   logic [1:0]  irq_stat_ff,    nxt_irq_stat;
   logic [1:0]  irq_mask_ff,    nxt_irq_mask;
   logic [31:0] prdata_ff,      nxt_prdata;
   logic        pready_ff,      nxt_pready;
   logic        pslverr_ff,     nxt_pslverr;
   logic        irq_ff,         nxt_irq;
   // synchronisers and edge history
   logic [1:0]  xtal_sync_ff,   nxt_xtal_sync;
   logic [1:0]  comp_sync_ff,   nxt_comp_sync;
   logic        xtal_d_ff,      nxt_xtal_d;
   logic        comp_d_ff,      nxt_comp_d;
   // datapath
   mcc_pkg::mcc_path_s path_ff, nxt_path;
   logic        path_vld_ff,    nxt_path_vld;
   mcc_pkg::mcc_smp_t  i1_dly_ff, nxt_i1_dly;
   mcc_pkg::mcc_smp_t  i2_dly_ff, nxt_i2_dly;
   // bus decode helpers
   logic [13:0] idx;
   logic        setup;
   logic        wr_fire;
   logic        mapped;
   logic [7:0]  rd_byte;
   logic [7:0]  analog_word;

   // signed power-of-two gain with sign, codes above five saturate
   function automatic mcc_pkg::mcc_out_t apply_gain(
      input mcc_pkg::mcc_smp_t s,
      input logic              neg,
      input logic [2:0]        e
   );
      logic [2:0]        e_sat;
      mcc_pkg::mcc_out_t wide;
      e_sat = 3'h0;
      wide  = 30'sh0;
      e_sat = (e > `MCC_EXP_MAX) ? `MCC_EXP_MAX : e;
      wide  = mcc_pkg::mcc_out_t'(s) <<< e_sat;
      apply_gain = neg ? -wide : wide;
   endfunction

   // a disabled input contributes zeros instead of samples
   function automatic mcc_pkg::mcc_smp_t gate(
      input mcc_pkg::mcc_smp_t s,
      input logic              en
   );
      gate = en ? s : 24'sh0;
   endfunction

   // apb phase decode; word index from the byte address
   assign idx     = paddr_i[15:2];
   assign setup   = psel_i & ~penable_i;
   assign wr_fire = psel_i & penable_i & pready_ff & pwrite_i;

   // fixed field and live status form the analog word
   always_comb begin
      analog_word = 8'h00;
      analog_word[`MCC_XTAL_FAIL_BIT] = xtal_sync_ff[1];
      analog_word[`MCC_COMP_BIT] = comp_sync_ff[1];
      analog_word[4:2] = `MCC_ANA_FIXED;
   end

   // address decode for reads and the error answer
   always_comb begin
      rd_byte = 8'h00;
      mapped  = 1'b1;
      if (idx == `MCC_IDX_PLL_GRID) begin
         rd_byte = pll_grid_ff;
      end else if (idx == `MCC_IDX_ANALOG) begin
         rd_byte = analog_word;
      end else if (idx == `MCC_IDX_CHAN_EN) begin
         rd_byte = chan_en_ff;
      end else if (idx == `MCC_IDX_GAIN) begin
         rd_byte = gain_ff;
      end else if (idx == `MCC_IDX_FILTER_GAIN) begin
         rd_byte = filt_gain_ff;
      end else if (idx == `MCC_IDX_IRQ_STATUS) begin
         rd_byte = {6'h00, irq_stat_ff};
      end else if (idx == `MCC_IDX_IRQ_MASK) begin
         rd_byte = {6'h00, irq_mask_ff};
      end else begin
         mapped = 1'b0;
      end
   end

   // bus answer: one wait-free access phase, data latched in setup
   always_comb begin
      nxt_pready  = setup;
      nxt_prdata  = pready_ff ? 32'h0000_0000 : prdata_ff;
      nxt_pslverr = 1'b0;
      if (setup) begin
         nxt_prdata  = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         nxt_pslverr = ~mapped;
      end
   end

   // register writes; reserved pll bits are stored as written
   always_comb begin
      nxt_pll_grid  = pll_grid_ff;
      nxt_chan_en   = chan_en_ff;
      nxt_gain      = gain_ff;
      nxt_filt_gain = filt_gain_ff;
      nxt_irq_mask  = irq_mask_ff;
      if (wr_fire) begin
         if (idx == `MCC_IDX_PLL_GRID) begin
            nxt_pll_grid = pwdata_i[7:0];
         end else if (idx == `MCC_IDX_CHAN_EN) begin
            nxt_chan_en = pwdata_i[7:0];
         end else if (idx == `MCC_IDX_GAIN) begin
            nxt_gain = pwdata_i[7:0];
         end else if (idx == `MCC_IDX_FILTER_GAIN) begin
            nxt_filt_gain = pwdata_i[7:0];
         end else if (idx == `MCC_IDX_IRQ_MASK) begin
            nxt_irq_mask = pwdata_i[1:0];
         end
      end
   end

   // sticky events, a new event beats a write-one clear
   always_comb begin
      nxt_xtal_sync = {xtal_sync_ff[0], crystal_fail_i};
      nxt_comp_sync = {comp_sync_ff[0], comp_out_i};
      nxt_xtal_d    = xtal_sync_ff[1];
      nxt_comp_d    = comp_sync_ff[1];
      nxt_irq_stat  = irq_stat_ff;
      if (wr_fire && idx == `MCC_IDX_IRQ_STATUS) begin
         nxt_irq_stat = irq_stat_ff & ~pwdata_i[1:0];
      end
      if (xtal_sync_ff[1] & ~xtal_d_ff) begin
         nxt_irq_stat[`MCC_IRQ_XTAL_BIT] = 1'b1;
      end
      if (comp_sync_ff[1] ^ comp_d_ff) begin
         nxt_irq_stat[`MCC_IRQ_COMP_BIT] = 1'b1;
      end
      nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
   end

   // routing, gating, phase alignment and gain per sample
   always_comb begin
      mcc_pkg::mcc_smp_t ia_g;
      mcc_pkg::mcc_smp_t ib_g;
      mcc_pkg::mcc_smp_t c1;
      mcc_pkg::mcc_smp_t c2;
      mcc_pkg::mcc_smp_t v_g;
      mcc_pkg::mcc_out_t v_scaled;
      ia_g         = 24'sh0;
      ib_g         = 24'sh0;
      c1           = 24'sh0;
      c2           = 24'sh0;
      v_g          = 24'sh0;
      v_scaled     = 30'sh0;
      nxt_path     = path_ff;
      nxt_path_vld = smp_valid_i;
      nxt_i1_dly   = i1_dly_ff;
      nxt_i2_dly   = i2_dly_ff;
      ia_g = chan_en_ff[`MCC_SWAP_BIT] ? smp_i.ib : smp_i.ia;
      ib_g = chan_en_ff[`MCC_SWAP_BIT] ? smp_i.ia : smp_i.ib;
      c1 = gate(ia_g, chan_en_ff[`MCC_I1_IN_BIT]);
      c2 = gate(ib_g, chan_en_ff[`MCC_I2_IN_BIT]);
      v_g = gate(smp_i.v, chan_en_ff[`MCC_V_IN_BIT]);
      if (smp_valid_i) begin
         nxt_i1_dly = c1;
         nxt_i2_dly = c2;
         if (chan_en_ff[`MCC_PHC_EN_BIT]) begin
            c1 = i1_dly_ff;
            c2 = i2_dly_ff;
         end
         v_scaled = apply_gain(v_g, gain_ff[`MCC_V_SIGN_BIT],
                               gain_ff[`MCC_V_EXP_HI:`MCC_V_EXP_LO]);
         if (filt_gain_ff[`MCC_V_QUARTER_BIT]) begin
            v_scaled = v_scaled >>> `MCC_QUARTER_SHIFT;
         end
         nxt_path.v = v_scaled;
         nxt_path.i1 = apply_gain(c1, gain_ff[`MCC_I1_SIGN_BIT],
                                  gain_ff[`MCC_I1_EXP_HI:`MCC_I1_EXP_LO]);
         // second current gain lives elsewhere, passed at unity
         nxt_path.i2 = mcc_pkg::mcc_out_t'(c2);
         nxt_path.aux = mcc_pkg::mcc_out_t'(gate(smp_i.aux,
                                                 chan_en_ff[`MCC_AUX_IN_BIT]));
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pll_grid_ff  <= `MCC_RST_PLL_GRID;
         chan_en_ff   <= `MCC_RST_CHAN_EN;
         gain_ff      <= `MCC_RST_GAIN;
         filt_gain_ff <= `MCC_RST_FILTER_GAIN;
         irq_stat_ff  <= `MCC_RST_IRQ;
         irq_mask_ff  <= `MCC_RST_IRQ;
         prdata_ff    <= 32'h0000_0000;
         pready_ff    <= 1'b0;
         pslverr_ff   <= 1'b0;
         irq_ff       <= 1'b0;
         xtal_sync_ff <= 2'h0;
         comp_sync_ff <= 2'h0;
         xtal_d_ff    <= 1'b0;
         comp_d_ff    <= 1'b0;
         path_ff      <= '0;
         path_vld_ff  <= 1'b0;
         i1_dly_ff    <= 24'sh0;
         i2_dly_ff    <= 24'sh0;
      end else begin
         pll_grid_ff  <= nxt_pll_grid;
         chan_en_ff   <= nxt_chan_en;
         gain_ff      <= nxt_gain;
         filt_gain_ff <= nxt_filt_gain;
         irq_stat_ff  <= nxt_irq_stat;
         irq_mask_ff  <= nxt_irq_mask;
         prdata_ff    <= nxt_prdata;
         pready_ff    <= nxt_pready;
         pslverr_ff   <= nxt_pslverr;
         irq_ff       <= nxt_irq;
         xtal_sync_ff <= nxt_xtal_sync;
         comp_sync_ff <= nxt_comp_sync;
         xtal_d_ff    <= nxt_xtal_d;
         comp_d_ff    <= nxt_comp_d;
         path_ff      <= nxt_path;
         path_vld_ff  <= nxt_path_vld;
         i1_dly_ff    <= nxt_i1_dly;
         i2_dly_ff    <= nxt_i2_dly;
      end
   end

   // outputs straight from flip-flops
   assign prdata_o                = prdata_ff;
   assign pready_o                = pready_ff;
   assign pslverr_o               = pslverr_ff;
   assign path_o                  = path_ff;
   assign path_valid_o            = path_vld_ff;
   assign irq_o                   = irq_ff;
   assign grid_freq_select_o      = pll_grid_ff[`MCC_GRID_SEL_BIT];
   assign clk_src_rc_o            = xtal_sync_ff[1];
   assign phase_comp_enable_o     = chan_en_ff[`MCC_PHC_EN_BIT];
   assign aux_processing_enable_o = chan_en_ff[`MCC_AUX_PROC_BIT];

   // checks
   sequence s_setup_cyc;
      psel_i && !penable_i;
   endsequence

   sequence s_grid_wr;
      wr_fire && idx == `MCC_IDX_PLL_GRID;
   endsequence

   a_bus_ready_next: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      s_setup_cyc |=> pready_o)
      else $error("pready not raised after setup");

   a_grid_select: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      s_grid_wr |=> grid_freq_select_o == $past(pwdata_i[5]))
      else $error("grid select not taken from write");

   a_xtal_rc_sw: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $rose(crystal_fail_i) |-> ##2 clk_src_rc_o)
      else $error("rc source not selected on crystal fail");

   a_analog_read: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      s_setup_cyc ##0 (idx == `MCC_IDX_ANALOG && !pwrite_i)
      |=> prdata_o[4:2] == `MCC_ANA_FIXED && prdata_o[5] == $past(comp_sync_ff[1]))
      else $error("analog word readback wrong");

   a_v_zero_gate: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      smp_valid_i && !chan_en_ff[0] |=> path_o.v == 30'sh0)
      else $error("voltage not zeroed when disabled");

   a_aux_zero_gate: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      smp_valid_i && !chan_en_ff[3] |=> path_o.aux == 30'sh0)
      else $error("aux not zeroed when disabled");

   a_swap_route: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      smp_valid_i && chan_en_ff[6:5] == 2'b01 && chan_en_ff[2]
      |=> path_o.i2 == 30'(signed'($past(smp_i.ia))))
      else $error("swap routing wrong");

   a_v_quarter: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      smp_valid_i && chan_en_ff[0] && !gain_ff[3] && gain_ff[2:0] <= `MCC_EXP_MAX
      && filt_gain_ff[5]
      |=> path_o.v == ((30'(signed'($past(smp_i.v))) <<< $past(gain_ff[2:0])) >>> 2))
      else $error("quarter voltage gain wrong");

   a_i1_neg_sat: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      smp_valid_i && chan_en_ff[6:1] == 6'h01 && gain_ff[7:4] == 4'hF
      |=> path_o.i1 == -(30'(signed'($past(smp_i.ia))) <<< 5))
      else $error("first current gain not saturated and negated");

   a_irq_level: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      irq_o == |(irq_stat_ff & irq_mask_ff))
      else $error("irq level mismatch");

endmodule
`default_nettype wire

// ### tb/mcc_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcc_map.svh"
module testbench;
   // one note per apb transfer and per sample
   typedef struct packed {
      logic       wr;
      logic [7:0] d;
      logic       e;
   } mcc_note_s;
   typedef struct packed {
      mcc_pkg::mcc_path_s p;
      logic [119:0]       m;
   } mcc_pnote_s;
   logic               core_clk_i;
   logic               rst_b_i;
   logic               psel_i;
   logic               penable_i;
   logic               pwrite_i;
   logic [15:0]        paddr_i;
   logic [31:0]        pwdata_i;
   logic [31:0]        prdata_o;
   logic               pready_o;
   logic               pslverr_o;
   logic               crystal_fail_i;
   logic               comp_out_i;
   logic               smp_valid_i;
   mcc_pkg::mcc_smp_s  smp_i;
   mcc_pkg::mcc_path_s path_o;
   logic               path_valid_o;
   logic               grid_freq_select_o;
   logic               clk_src_rc_o;
   logic               phase_comp_enable_o;
   logic               aux_processing_enable_o;
   logic               irq_o;
   int                 errors;
   int                 comparisons;
   mcc_note_s          aq[$];
   mcc_pnote_s         pq[$];
   mcc_note_s          an;
   mcc_pnote_s         pn;
   mcc_regs mcc_regs_inst (.core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .crystal_fail_i, .comp_out_i, .smp_valid_i, .smp_i, .path_o,
      .path_valid_o, .grid_freq_select_o, .clk_src_rc_o, .phase_comp_enable_o, .aux_processing_enable_o,
      .irq_o);
   task automatic check(input logic [119:0] seen, input logic [119:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // apb master: one idle edge first so no signal is assigned twice in a step
   task automatic ap(input logic w, input logic [13:0] idx, input logic [7:0] wd, input logic [7:0] xd,
                     input logic xe);
      @(posedge core_clk_i);
      aq.push_back('{w, xd, xe});
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= {idx, 2'b00};
      pwdata_i  <= {24'($urandom()), wd};
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      // no wait-state count assumed, the watchdog bounds a hang
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'b1);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      ap(1'b1, idx, d, 8'h00, 1'b0);
   endtask
   task automatic rd(input logic [13:0] idx, input logic [7:0] x);
      ap(1'b0, idx, 8'h00, x, 1'b0);
   endtask
   task automatic defaults();
      logic [13:0] idx [6] = '{`MCC_IDX_PLL_GRID, `MCC_IDX_CHAN_EN, `MCC_IDX_GAIN, `MCC_IDX_FILTER_GAIN,
                               `MCC_IDX_IRQ_STATUS, `MCC_IDX_IRQ_MASK};
      foreach (idx[i]) rd(idx[i], 8'h00);
      check({grid_freq_select_o, phase_comp_enable_o, aux_processing_enable_o, irq_o}, 4'h0);
   endtask
   // reference datapath, settings held constant over a burst
   function automatic mcc_pkg::mcc_path_s model(input mcc_pkg::mcc_smp_s s, input logic [7:0] ch,
                                                input logic [7:0] g, input logic q);
      mcc_pkg::mcc_path_s r;
      r.v   = s.v;
      r.i1  = ch[5] ? s.ib : s.ia;
      r.i2  = ch[5] ? s.ia : s.ib;
      r.aux = s.aux;
      if (!ch[0]) r.v = '0;
      if (!ch[1]) r.i1 = '0;
      if (!ch[2]) r.i2 = '0;
      if (!ch[3]) r.aux = '0;
      // codes six and seven act as five
      r.v = r.v <<< ((g[2:0] > `MCC_EXP_MAX) ? `MCC_EXP_MAX : g[2:0]);
      if (g[3]) r.v = -r.v;
      if (q) r.v = r.v >>> 2;
      r.i1 = r.i1 <<< ((g[6:4] > `MCC_EXP_MAX) ? `MCC_EXP_MAX : g[6:4]);
      if (g[7]) r.i1 = -r.i1;
      return r;
   endfunction
   // watcher: pairs each result with the oldest note
   always @(posedge core_clk_i) begin
      if (psel_i && penable_i && pready_o === 1'b1) begin
         if (aq.size() == 0) check(1'b1, 1'b0);
         else begin
            an = aq.pop_front();
            check(pslverr_o, an.e);
            if (!an.wr) check(prdata_o, {24'h0, an.d});
         end
      end
      if (path_valid_o === 1'b1) begin
         if (pq.size() == 0) check(1'b1, 1'b0);
         else begin
            pn = pq.pop_front();
            check(path_o & pn.m, pn.p & pn.m);
         end
      end
   end
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge core_clk_i);
      errors++;
      results();
   end
   initial begin
      mcc_pkg::mcc_smp_s  s;
      mcc_pkg::mcc_path_s e;
      mcc_pkg::mcc_path_s pv;
      mcc_pnote_s         n;
      logic [7:0]         ch;
      logic [7:0]         g;
      logic               q;
      {rst_b_i, psel_i, penable_i, pwrite_i, crystal_fail_i, comp_out_i, smp_valid_i} = '0;
      paddr_i = '0;
      pwdata_i = '0;
      smp_i = '0;
      pv = '0;
      errors = 0;
      comparisons = 0;
      void'($urandom(70));
      repeat (6) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      defaults();
      // reserved low bits written as zero
      wr(`MCC_IDX_PLL_GRID, 8'h20);
      rd(`MCC_IDX_PLL_GRID, 8'h20);
      check(grid_freq_select_o, 1'b1);
      wr(`MCC_IDX_PLL_GRID, 8'h00);
      rd(`MCC_IDX_ANALOG, 8'h14);
      check(grid_freq_select_o, 1'b0);
      crystal_fail_i <= 1'b1;
      comp_out_i     <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      rd(`MCC_IDX_ANALOG, 8'hB4);
      check(clk_src_rc_o, 1'b1);
      // read-only status ignores writes, unmapped index answers with an error
      ap(1'b1, `MCC_IDX_ANALOG, 8'h00, 8'h00, 1'b0);
      rd(`MCC_IDX_ANALOG, 8'hB4);
      ap(1'b0, 14'h2870, 8'h00, 8'h00, 1'b1);
      ap(1'b1, 14'h2870, 8'hFF, 8'h00, 1'b1);
      // both events latched but masked
      rd(`MCC_IDX_IRQ_STATUS, 8'h03);
      check(irq_o, 1'b0);
      wr(`MCC_IDX_IRQ_MASK, 8'h01);
      repeat (2) @(posedge core_clk_i);
      check(irq_o, 1'b1);
      wr(`MCC_IDX_IRQ_STATUS, 8'h01);
      rd(`MCC_IDX_IRQ_STATUS, 8'h02);
      check(irq_o, 1'b0);
      wr(`MCC_IDX_IRQ_MASK, 8'h02);
      repeat (2) @(posedge core_clk_i);
      check(irq_o, 1'b1);
      wr(`MCC_IDX_IRQ_STATUS, 8'h02);
      rd(`MCC_IDX_IRQ_STATUS, 8'h00);
      check(irq_o, 1'b0);
      // falling comparator is an event, falling crystal fail is not
      crystal_fail_i <= 1'b0;
      comp_out_i     <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      rd(`MCC_IDX_IRQ_STATUS, 8'h02);
      rd(`MCC_IDX_ANALOG, 8'h14);
      check({clk_src_rc_o, irq_o}, 2'b01);
      wr(`MCC_IDX_IRQ_STATUS, 8'h02);
      wr(`MCC_IDX_IRQ_MASK, 8'h00);
      // every exponent 0..5 on both paths, signs, swap and gates varied
      for (int it = 0; it < 13; it++) begin
         ch = {1'b0, it[1], it[0], 5'($urandom())};
         g  = {it[2], 3'(it % 6), it[3] ^ it[0], 3'(5 - it % 6)}; // exponents kept in 0..5
         q  = it[2] ^ it[1];
         if (it == 12) begin
            // deliberate out-of-range probe: exponent seven, both signs negative
            ch = 8'h03;
            g  = 8'hFF;
            q  = 1'b0;
         end
         wr(`MCC_IDX_CHAN_EN, ch);
         wr(`MCC_IDX_GAIN, g);
         wr(`MCC_IDX_FILTER_GAIN, {2'b00, q, 5'h00});
         rd(`MCC_IDX_CHAN_EN, ch);
         rd(`MCC_IDX_GAIN, g);
         check({phase_comp_enable_o, aux_processing_enable_o}, {ch[6], ch[4]});
         // back-to-back samples; first delayed current after a change is unknown
         for (int k = 0; k < 4; k++) begin
            @(posedge core_clk_i);
            s = {$urandom(), $urandom(), $urandom()};
            e = model(s, ch, g, q);
            n.p = e;
            n.m = '1;
            if (ch[6]) begin
               n.p.i1 = pv.i1;
               n.p.i2 = pv.i2;
               if (k == 0) n.m[89:30] = '0;
            end
            pv = e;
            pq.push_back(n);
            smp_valid_i <= 1'b1;
            smp_i       <= s;
         end
         @(posedge core_clk_i);
         smp_valid_i <= 1'b0;
      end
      // second reset in mid-run
      @(posedge core_clk_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      defaults();
      repeat (3) @(posedge core_clk_i);
      check(aq.size() + pq.size(), 0);
      results();
   end
endmodule
`default_nettype wire
